// ==== prs_pkg.sv ====
// Purpose: constants and types for the reset and power status register block
// Assumes: one clock, registers reached at their printed offsets on a plain debug port
// Notes: layout fixed by the status register field map
//
// What this block does
// - reset flag bit 2 reads 1 while non-debug logic is held in reset
// - reset flag read-only; unknown, write-ignored when unpowered or double locked
// - state-lost bit reads 1 when core debug state lost, else 0
// - state-lost bit set to 1 on cold reset
// - double locked with newer revision: state-lost bit reads 0
// - state-lost reads zero when unpowered, unknown when locked, else read-only
// - with debug power domain feature, live bit 0 always reads one
// - newer revision without the feature: live bit reads 1 only when powered and not double locked
// - older revision, powered and locked: live bit value is implementation choice
// - qualifying read clears restrict, monitor, access and state-lost sticky bits
// - read clears sticky core reset bit only when reset flag reads 0
// - under double lock the read clearing may be done or skipped
// - unpowered without feature: state-lost bit does not clear on read
// - read clearing is treated as an indirect write of the register
// - status register sits at offset 0x314 of the debug component
// - accesses read-only when feature present or powered, otherwise error
// - unpowered without feature: state-lost value implementation defined
// - status and control word is 32 bits, bits 30:29 mirror comms status
// - sticky core reset bit set on warm reset, held until qualifying read
package prs_pkg;
    localparam int PRS_AW = 12;
    localparam int PRS_DW = 32;
    localparam logic [PRS_AW-1:0] PRS_STATUS_OFF = 12'h314;
    localparam logic [PRS_AW-1:0] PRS_CTRL_OFF = 12'h088;
    localparam int PRS_BIT_LIVE = 0;
    localparam int PRS_BIT_LOST = 1;
    localparam int PRS_BIT_RST = 2;
    localparam int PRS_BIT_RSTSEEN = 3;
    localparam int PRS_BIT_DLK = 6;
    localparam int PRS_BIT_DAD = 7;
    localparam int PRS_BIT_DRESTR = 11;
    localparam int PRS_BIT_MAD = 10;
    localparam int PRS_MIR_HI = 30;
    localparam int PRS_MIR_LO = 29;
    localparam logic PRS_LOST_RST = 1'b1;
    localparam logic PRS_SEEN_RST = 1'b1;
    typedef enum logic [1:0] {PRS_ACC_OK, PRS_ACC_ERR, PRS_ACC_UNMAP} prs_acc_e;
endpackage : prs_pkg

// ==== prs_sticky_if.sv ====
// Purpose: carries sticky set and clear events between block modules
// Assumes: single clock domain
// Notes: sets come from the core side, clears from the read path
`timescale 1ns/100ps
interface prs_sticky_if;
    logic [3:0] set_ev;
    logic [3:0] clr_ev;
    logic [3:0] val;
    modport src (output set_ev, output clr_ev, input val);
    modport hold (input set_ev, input clr_ev, output val);
endinterface : prs_sticky_if

// ==== prs_sticky.sv ====
// Purpose: holds the four read-clear sticky bits
// Assumes: set events are single-cycle or level
// Notes: set wins over clear in the same cycle
`timescale 1ns/100ps
module prs_sticky #(
    parameter logic [3:0] RST_VAL = 4'h0
) (
    input wire logic clk,
    input wire logic reset_n,
    prs_sticky_if.hold sb
);
    import prs_pkg::*;
    logic [3:0] val_r;
    // ------------------------------------------------------------
    // sticky storage
    // ------------------------------------------------------------
    // a set arriving with a read clear must not be lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            val_r <= RST_VAL;
        end else begin
            val_r <= (val_r & ~sb.clr_ev) | sb.set_ev;
        end
    end
    assign sb.val = val_r;
    chk_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
        |sb.set_ev |-> ##1 ((val_r & $past(sb.set_ev)) == $past(sb.set_ev)))
        else $error("sticky set lost");
endmodule : prs_sticky

// ==== prs_status_top.sv ====
// Purpose: reset and power status register seen by the external debugger
// Assumes: debug port is a simple read/write strobe port, answer one cycle later
// Notes: unknown-value cases return zero; restrict, monitor and access sticky bits in a submodule, state-lost and reset-seen bits here
`timescale 1ns/100ps
module prs_status_top #(
    parameter bit HAS_DPD = 1'b0,
    parameter bit HAS_DBL_LOCK = 1'b1,
    parameter bit HAS_REV_TWO = 1'b1,
    parameter bit LOCKED_LIVE_ONE = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic warm_reset_n,
    input wire logic core_domain_on,
    input wire logic pe_in_reset,
    input wire logic dbl_lock_engaged,
    input wire logic state_lost_ev,
    input wire logic debug_restrict_ev,
    input wire logic monitor_access_off_ev,
    input wire logic debug_access_off_ev,
    input wire logic [1:0] comms_status_mirror,
    input wire logic dbg_sel,
    input wire logic dbg_wr,
    input wire logic [prs_pkg::PRS_AW-1:0] dbg_addr,
    input wire logic [prs_pkg::PRS_DW-1:0] dbg_wdata,
    output logic [prs_pkg::PRS_DW-1:0] dbg_rdata,
    output logic dbg_ack,
    output logic dbg_err,
    output logic indirect_wr
);
    import prs_pkg::*;

    // ------------------------------------------------------------
    // access qualifiers
    // ------------------------------------------------------------
    logic locked;
    logic unpowered;
    logic live;
    logic rd_status;
    logic clr_ok;
    prs_acc_e acc;
    assign locked = HAS_DBL_LOCK && dbl_lock_engaged;
    assign unpowered = !HAS_DPD && !core_domain_on;
    // live bit forced high with the power domain feature
    assign live = HAS_DPD ? 1'b1
        : (core_domain_on && (!locked || (!HAS_REV_TWO && LOCKED_LIVE_ONE)));

    // decode one access to an access class
    function automatic prs_acc_e prs_classify(input logic [PRS_AW-1:0] a);
        if (a == PRS_STATUS_OFF) begin
            return (HAS_DPD || core_domain_on) ? PRS_ACC_OK : PRS_ACC_ERR;
        end else if (a == PRS_CTRL_OFF) begin
            return PRS_ACC_OK;
        end
        return PRS_ACC_UNMAP;
    endfunction : prs_classify

    assign acc = prs_classify(dbg_addr);
    assign rd_status = dbg_sel && !dbg_wr && acc == PRS_ACC_OK
        && dbg_addr == PRS_STATUS_OFF;
    // clear skipped under double lock: allowed, and simpler to reason about
    assign clr_ok = rd_status && core_domain_on && !locked;

    // ------------------------------------------------------------
    // sticky bits
    // ------------------------------------------------------------
    prs_sticky_if sb ();
    logic rst_seen_r;
    logic lost_r;
    assign sb.set_ev = {debug_restrict_ev, monitor_access_off_ev, debug_access_off_ev,
        state_lost_ev};
    assign sb.clr_ev = {4{clr_ok}};
    prs_sticky #(.RST_VAL(4'h0)) u_sticky (
        .clk(clk),
        .reset_n(reset_n),
        .sb(sb)
    );

    // state lost: cold reset sets it, core power loss sets it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lost_r <= PRS_LOST_RST;
        end else if (state_lost_ev || !core_domain_on) begin
            lost_r <= 1'b1;
        end else if (clr_ok) begin
            lost_r <= 1'b0;
        end
    end

    // core reset seen: warm reset sets it; cleared only if reset flag reads 0
    always_ff @(posedge clk or negedge warm_reset_n) begin
        if (!warm_reset_n) begin
            rst_seen_r <= PRS_SEEN_RST;
        end else if (pe_in_reset) begin
            rst_seen_r <= 1'b1;
        end else if (clr_ok) begin
            rst_seen_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [PRS_DW-1:0] status_word;
    logic [PRS_DW-1:0] ctrl_word;
    logic hide;
    assign hide = unpowered || locked;
    always_comb begin
        status_word = '0;
        status_word[PRS_BIT_LIVE] = live;
        // zero when unpowered or locked; locked unknown value returned as zero
        status_word[PRS_BIT_LOST] = (hide) ? 1'b0 : lost_r;
        status_word[PRS_BIT_RST] = hide ? 1'b0 : pe_in_reset;
        status_word[PRS_BIT_RSTSEEN] = hide ? 1'b0 : rst_seen_r;
        status_word[PRS_BIT_DLK] = HAS_DBL_LOCK && core_domain_on && locked;
        status_word[PRS_BIT_DAD] = hide ? 1'b0 : sb.val[1];
        status_word[PRS_BIT_MAD] = hide ? 1'b0 : sb.val[2];
        status_word[PRS_BIT_DRESTR] = hide ? 1'b0 : sb.val[3];
        ctrl_word = '0;
        ctrl_word[PRS_MIR_HI:PRS_MIR_LO] = comms_status_mirror;
    end

    // ------------------------------------------------------------
    // debug port answer
    // ------------------------------------------------------------
    // writes are ignored everywhere: every field is read-only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dbg_rdata <= '0;
            dbg_ack <= 1'b0;
            dbg_err <= 1'b0;
            indirect_wr <= 1'b0;
        end else begin
            dbg_ack <= dbg_sel;
            dbg_err <= dbg_sel && acc != PRS_ACC_OK;
            indirect_wr <= clr_ok;
            if (dbg_sel && !dbg_wr && acc == PRS_ACC_OK) begin
                dbg_rdata <= (dbg_addr == PRS_STATUS_OFF) ? status_word : ctrl_word;
            end else begin
                dbg_rdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_reset_flag_read: assert property (@(posedge clk) disable iff (!reset_n)
        rd_status && !hide |-> ##1 dbg_rdata[PRS_BIT_RST] == $past(pe_in_reset))
        else $error("reset flag wrong");
    chk_reset_flag_hidden: assert property (@(posedge clk) disable iff (!reset_n)
        rd_status && hide |-> ##1 !dbg_rdata[PRS_BIT_RST])
        else $error("reset flag not hidden");
    chk_lost_cleared: assert property (@(posedge clk) disable iff (!reset_n)
        clr_ok && !state_lost_ev ##1 core_domain_on && !state_lost_ev |-> !lost_r)
        else $error("state lost not cleared");
    chk_lost_locked_zero: assert property (@(posedge clk) disable iff (!reset_n)
        rd_status && locked |-> ##1 !dbg_rdata[PRS_BIT_LOST])
        else $error("state lost under lock");
    chk_live_bit: assert property (@(posedge clk) disable iff (!reset_n)
        rd_status && core_domain_on && !locked |=> dbg_rdata[PRS_BIT_LIVE])
        else $error("live bit low while accessible");
    // with the newer revision a locked core must not look accessible
    chk_live_locked: assert property (@(posedge clk) disable iff (!reset_n)
        rd_status && locked && HAS_REV_TWO && !HAS_DPD |=> !dbg_rdata[PRS_BIT_LIVE])
        else $error("live bit high under lock");
    chk_seen_kept: assert property (@(posedge clk) disable iff (!reset_n)
        clr_ok && pe_in_reset |=> rst_seen_r)
        else $error("reset seen cleared in reset");
    chk_err_unpowered: assert property (@(posedge clk) disable iff (!reset_n)
        dbg_sel && dbg_addr == PRS_STATUS_OFF && unpowered |=> dbg_err)
        else $error("no error when unpowered");
    chk_indirect_write: assert property (@(posedge clk) disable iff (!reset_n)
        clr_ok |=> indirect_wr)
        else $error("indirect write missing");
    chk_lost_on_power: assert property (@(posedge clk) disable iff (!reset_n)
        !core_domain_on |=> lost_r)
        else $error("power loss not seen");
    chk_mirror_bits: assert property (@(posedge clk) disable iff (!reset_n)
        dbg_sel && !dbg_wr && dbg_addr == PRS_CTRL_OFF |=>
        dbg_rdata[PRS_MIR_HI:PRS_MIR_LO] == $past(comms_status_mirror))
        else $error("mirror bits wrong");
    cov_clear_read: cover property (@(posedge clk) disable iff (!reset_n) clr_ok);
    cov_locked_read: cover property (@(posedge clk) disable iff (!reset_n) rd_status && locked);
    cov_err_access: cover property (@(posedge clk) disable iff (!reset_n) dbg_sel && unpowered);
    cov_read_in_reset: cover property (@(posedge clk) disable iff (!reset_n)
        rd_status && pe_in_reset);
endmodule : prs_status_top

// ==== prs_dbg_model.sv ====
// Purpose: external debugger stand-in issuing word accesses to the status block
// Assumes: fixed one-cycle answer, one-cycle request strobe
// Notes: released address and data show inverted values, never stale ones
`timescale 1ns/100ps
module prs_dbg_model (
    input wire logic clk,
    output logic sel,
    output logic wr,
    output logic [prs_pkg::PRS_AW-1:0] addr,
    output logic [prs_pkg::PRS_DW-1:0] wdata,
    input wire logic [prs_pkg::PRS_DW-1:0] rdata,
    input wire logic ack,
    input wire logic err,
    input wire logic iwr
);
    import prs_pkg::*;
    initial begin
        sel = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
    end
    // one access: strobe for one edge only, since a held strobe would count as a second access;
    // the answer is taken at the next rising edge, while it still stands
    task automatic access(input logic w, input logic [PRS_AW-1:0] a, input logic [PRS_DW-1:0] d,
        output logic [PRS_DW-1:0] q, output logic a_o, output logic e_o, output logic iw_o);
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        sel <= 1'b0;
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        @(posedge clk);
        q = rdata;
        a_o = ack;
        e_o = err;
        iw_o = iwr;
    endtask : access
endmodule : prs_dbg_model

// ==== pe_reset_power_status_reg_tb_top.sv ====
// Purpose: self-checking bench for the reset and power status block
// Assumes: default parameters, no debug power domain, newer revision
// Notes: unknown-value reads expected as zero, lock bit masked while locked
`timescale 1ns/100ps
module pe_reset_power_status_reg_tb_top;
    import prs_pkg::*;
    logic clk, reset_n, warm_reset_n, core_on, pe_rst, lk, sel, wr, ack, err, iwr;
    logic a_s, e_s, iw_s, seen;
    logic [3:0] ev, stk;
    logic [1:0] mir;
    logic [PRS_AW-1:0] addr;
    logic [PRS_DW-1:0] wdata, rdata, q;
    int fail_count, compares;
    int pos[4] = '{PRS_BIT_LOST, PRS_BIT_DRESTR, PRS_BIT_MAD, PRS_BIT_DAD};
    prs_status_top i_prs_status_top (.clk(clk), .reset_n(reset_n), .warm_reset_n(warm_reset_n),
        .core_domain_on(core_on), .pe_in_reset(pe_rst), .dbl_lock_engaged(lk),
        .state_lost_ev(ev[0]), .debug_restrict_ev(ev[1]), .monitor_access_off_ev(ev[2]),
        .debug_access_off_ev(ev[3]), .comms_status_mirror(mir), .dbg_sel(sel), .dbg_wr(wr),
        .dbg_addr(addr), .dbg_wdata(wdata), .dbg_rdata(rdata), .dbg_ack(ack), .dbg_err(err),
        .indirect_wr(iwr));
    prs_dbg_model i_prs_dbg_model (.clk(clk), .sel(sel), .wr(wr), .addr(addr), .wdata(wdata),
        .rdata(rdata), .ack(ack), .err(err), .iwr(iwr));
    // ------------------------------------------------------------
    // shared checking and model tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // status word the model predicts; all zero when not accessible
    function automatic logic [31:0] exp_st();
        logic [31:0] v;
        v = '0;
        if (core_on && !lk) begin
            v[PRS_BIT_LIVE] = 1'b1;
            v[PRS_BIT_RST] = pe_rst;
            v[PRS_BIT_RSTSEEN] = seen;
            foreach (stk[i]) v[pos[i]] = stk[i];
        end
        return v;
    endfunction : exp_st
    task automatic st_rd();
        logic [31:0] x, m;
        logic ok;
        // callers change inputs by nonblocking assignment just before the call, so predict
        // only once the access is over and those inputs have settled
        i_prs_dbg_model.access(1'b0, PRS_STATUS_OFF, '0, q, a_s, e_s, iw_s);
        x = exp_st();
        ok = core_on && !lk;
        m = lk ? 32'hFFFF_FFBF : 32'hFFFF_FFFF;
        chk(a_s, 1'b1);
        chk(e_s, !core_on);
        chk(q & m, x);
        chk(iw_s, ok);
        if (ok) begin
            stk = 4'h0;
            if (!pe_rst) seen = 1'b0;
        end
    endtask : st_rd
    task automatic pulse(input int i);
        @(posedge clk) ev[i] <= 1'b1;
        @(posedge clk) ev <= 4'h0;
        stk[i] = 1'b1;
    endtask : pulse
    task automatic tally_and_finish();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is about a hundred and ten cycles; a hang stops well past that
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        warm_reset_n = 1'b0;
        {core_on, pe_rst, lk, ev, mir} = {1'b1, 1'b0, 1'b0, 4'h0, 2'b00};
        stk = 4'h1;
        seen = 1'b1;
        void'($urandom(37));
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        warm_reset_n <= 1'b1;
        st_rd();
        st_rd();
        $display("test reset values done");
        @(posedge clk) pe_rst <= 1'b1;
        seen = 1'b1;
        st_rd();
        st_rd();
        @(posedge clk) pe_rst <= 1'b0;
        st_rd();
        st_rd();
        $display("test core reset sticky done");
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            st_rd();
            st_rd();
        end
        $display("test read clear done");
        pulse($urandom_range(3, 0));
        @(posedge clk) lk <= 1'b1;
        st_rd();
        @(posedge clk) lk <= 1'b0;
        st_rd();
        st_rd();
        $display("test double lock done");
        @(posedge clk) core_on <= 1'b0;
        repeat (3) @(posedge clk);
        stk[0] = 1'b1;
        st_rd();
        @(posedge clk) core_on <= 1'b1;
        st_rd();
        $display("test power loss done");
        @(posedge clk) warm_reset_n <= 1'b0;
        @(posedge clk) warm_reset_n <= 1'b1;
        seen = 1'b1;
        i_prs_dbg_model.access(1'b1, PRS_STATUS_OFF, $urandom(), q, a_s, e_s, iw_s);
        chk(iw_s, 1'b0);
        chk(a_s, 1'b1);
        chk(e_s, 1'b0);
        chk(q, 32'h0);
        st_rd();
        $display("test warm reset and write done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) mir <= k[1:0];
            i_prs_dbg_model.access(1'b0, PRS_CTRL_OFF, '0, q, a_s, e_s, iw_s);
            chk(q, {1'b0, mir, 29'h0});
        end
        i_prs_dbg_model.access(1'b0, 12'h100, '0, q, a_s, e_s, iw_s);
        chk(e_s, 1'b1);
        $display("test mirror and unmapped done");
        tally_and_finish();
    end
endmodule : pe_reset_power_status_reg_tb_top
